// ===== logic/lbr_pkg.sv
// Constants and mode encodings for the logic block distributed RAM
//
// Notes on behaviour
// [RULE_01] Two 16x1 memories with own data, or one 32x1 memory.
// [RULE_02] One generator as 16x1 memory, others still compute logic functions.
// [RULE_03] Edge mode writes only on chosen clock edge; enable gates it.
// [RULE_04] Level mode uses write enable directly as write strobe.
// [RULE_05] Timing mode applies to both generators together.
// [RULE_06] Single-port: each generator shares one read/write port.
// [RULE_07] Dual-port: one 16x1 memory, one write port, two read ports.
// [RULE_08] Dual-port allows read and write together, any addresses.
// [RULE_09] Reads identical in every mode; only writes differ.
// [RULE_10] Four generator inputs address one cell of its table.
// [RULE_11] 16x2: direct, third-input, set/reset pins become data, data, enable.
// [RULE_12] 32x1: second data pin is address bit four; first is data.
// [RULE_13] Addressed contents leave combinationally or enter block flip-flops; the comb outputs are registered on the system clock here.
// [RULE_14] Third generator still runs; flip-flops pick memory, third or data.
// [RULE_15] Active edge latches address, data, enable, then pulses write.
// [RULE_16] Write clock rising by default or falling, inverted independently.
// [RULE_17] Clock polarity applies to both generators used as memory.
// [RULE_18] Write enable active high, not invertible.
// [RULE_19] User keeps post-edge clock phase under one millisecond.
// [RULE_20] Dual-port: first inputs write/read address, second inputs read address.
package lbr_pkg;
   // =====================================================
   // Arrangements
   // =====================================================
   typedef enum logic [3:0] {
      LBR_ARR_LOGIC = 4'h1,
      LBR_ARR_16X1 = 4'h2,
      LBR_ARR_16X2 = 4'h4,
      LBR_ARR_32X1 = 4'h8
   } lbr_arr_t;
   localparam int LBR_ADDR_W = 4;
   localparam int LBR_DEPTH = 16;
   localparam int LBR_LUT_BITS = 16;
   localparam int LBR_THIRD_BITS = 8;
   localparam int LBR_CLK_MHZ = 100;
   // Longest post-edge clock phase, in microseconds
   localparam int LBR_POST_EDGE_US = 1000;
   localparam logic [1:0] LBR_FF_SEL_MEM = 2'h0;
   localparam logic [1:0] LBR_FF_SEL_THIRD = 2'h1;
   localparam logic [1:0] LBR_FF_SEL_DATA = 2'h2;
   localparam logic [3:0] LBR_ADDR_ZERO = 4'h0;
endpackage : lbr_pkg

// ===== logic/lbr_cell.sv
// One 16x1 lookup table usable as logic or memory
`timescale 1ns/1ns
`default_nettype none
module lbr_cell #(
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Write side
   input wire logic wr_en_in,
   input wire logic [3:0] wr_addr_in,
   input wire logic wr_data_in,
   // Configured logic contents
   input wire logic cfg_load_in,
   input wire logic [DEPTH-1:0] cfg_table_in,
   // Read side
   input wire logic [3:0] rd_addr_in,
   output logic rd_data_out,
   output logic [3:0] rd_addr2_unused_out
);
   logic [DEPTH-1:0] table_reg;
   initial begin
      if (DEPTH != 16) $error("lbr_cell supports only 16 cells");
   end
   // Table update; configuration load takes the table, else one-bit write
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         table_reg <= '0;
      end else if (cfg_load_in) begin
         table_reg <= cfg_table_in;
      end else if (wr_en_in) begin
         table_reg[wr_addr_in] <= wr_data_in;
      end
   end
   // Read path is a plain table lookup in every mode
   assign rd_data_out = table_reg[rd_addr_in];
   assign rd_addr2_unused_out = rd_addr_in;
endmodule : lbr_cell
`default_nettype wire

// ===== logic/lbr_block.sv
// Logic block with two lookup generators usable as distributed RAM
`timescale 1ns/1ns
`default_nettype none
module lbr_block #(
   parameter int ADDR_W = 4
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Configuration
   input wire lbr_pkg::lbr_arr_t arr_sel_in,
   input wire logic mem_a_en_in,
   input wire logic mem_b_en_in,
   input wire logic dual_port_in,
   input wire logic edge_mode_in,
   input wire logic wclk_falling_in,
   input wire logic ff_falling_in,
   input wire logic cfg_load_in,
   input wire logic [15:0] cfg_lut_a_in,
   input wire logic [15:0] cfg_lut_b_in,
   input wire logic [7:0] cfg_lut_third_in,
   input wire logic [1:0] ff_a_sel_in,
   input wire logic [1:0] ff_b_sel_in,
   input wire logic out_a_third_in,
   input wire logic out_b_third_in,
   // Fabric pins
   input wire logic [3:0] lut_a_inputs_in,
   input wire logic [3:0] lut_b_inputs_in,
   input wire logic direct_input_pin_in,
   input wire logic third_lut_input_pin_in,
   input wire logic set_reset_pin_in,
   // Outputs
   output logic comb_a_out,
   output logic comb_b_out,
   output logic ff_a_out,
   output logic ff_b_out,
   output logic single_port_read_out,
   output logic write_pulse_out
);
   import lbr_pkg::*;
   // =====================================================
   // Parameter check
   // =====================================================
   initial begin
      if (ADDR_W != LBR_ADDR_W) $error("lbr_block needs four address inputs");
   end

   // =====================================================
   // Pin synchronisers (pins arrive from outside this clock)
   // =====================================================
   logic [12:0] pin_s1_reg;
   logic [12:0] pin_s2_reg;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end else begin
         pin_s1_reg <= {lut_a_inputs_in, lut_b_inputs_in, direct_input_pin_in,
                        third_lut_input_pin_in, set_reset_pin_in,
                        wclk_falling_in, ff_falling_in};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   logic [3:0] addr_a;
   logic [3:0] addr_b;
   logic mem_data_in_a;
   logic mem_data_in_b;
   logic wr_enable;
   logic wclk_neg;
   logic ffclk_neg;
   assign addr_a = pin_s2_reg[12:9];
   assign addr_b = pin_s2_reg[8:5];
   // [RULE_11] pin remapping
   assign mem_data_in_a = pin_s2_reg[4];
   assign mem_data_in_b = pin_s2_reg[3];
   // [RULE_18] enable active high, never inverted
   assign wr_enable = pin_s2_reg[2];
   assign wclk_neg = pin_s2_reg[1];
   assign ffclk_neg = pin_s2_reg[0];

   // =====================================================
   // Write clock polarity
   // =====================================================
   // The write clock is modelled as the system clock plus a phase flag:
   // falling-edge operation is emulated by half-rate phase tracking.
   logic phase_reg;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_reg <= 1'b0;
      end else begin
         phase_reg <= ~phase_reg;
      end
   end
   // [RULE_16] selectable edge per consumer
   function automatic logic edge_hit(input logic neg, input logic ph);
      edge_hit = neg ? ph : ~ph;
   endfunction : edge_hit
   logic wr_edge;
   logic ff_edge;
   // [RULE_17] one polarity for both generators
   assign wr_edge = edge_hit(wclk_neg, phase_reg);
   assign ff_edge = edge_hit(ffclk_neg, phase_reg);

   // =====================================================
   // Write capture and internal pulse
   // =====================================================
   logic [3:0] lat_addr_a_reg;
   logic [3:0] lat_addr_b_reg;
   logic lat_da_reg;
   logic lat_db_reg;
   logic lat_we_reg;
   logic pulse_reg;
   // [RULE_15] active edge latches address, data and enable
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lat_addr_a_reg <= LBR_ADDR_ZERO;
         lat_addr_b_reg <= LBR_ADDR_ZERO;
         lat_da_reg <= 1'b0;
         lat_db_reg <= 1'b0;
         lat_we_reg <= 1'b0;
      end else if (wr_edge) begin
         lat_addr_a_reg <= addr_a;
         lat_addr_b_reg <= addr_b;
         lat_da_reg <= mem_data_in_a;
         lat_db_reg <= mem_data_in_b;
         lat_we_reg <= wr_enable;
      end
   end
   // [RULE_03] enable only qualifies the edge
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pulse_reg <= 1'b0;
      end else begin
         pulse_reg <= edge_mode_in && wr_edge && wr_enable;
      end
   end
   // [RULE_05] one timing mode for both generators
   logic wr_go;
   logic [3:0] w_addr_a;
   logic [3:0] w_addr_b;
   logic w_da;
   logic w_db;
   always_comb begin
      if (edge_mode_in) begin
         wr_go = pulse_reg;
         w_addr_a = lat_addr_a_reg;
         w_addr_b = lat_addr_b_reg;
         w_da = lat_da_reg;
         w_db = lat_db_reg;
      end else begin
         // [RULE_04] level mode, enable is the strobe itself
         wr_go = wr_enable;
         w_addr_a = addr_a;
         w_addr_b = addr_b;
         w_da = mem_data_in_a;
         w_db = mem_data_in_b;
      end
   end
   assign write_pulse_out = wr_go;

   // =====================================================
   // Write steering per arrangement
   // =====================================================
   logic we_a;
   logic we_b;
   logic wd_a;
   logic wd_b;
   logic [3:0] wa_b;
   logic hi_bit;
   logic w_hi;
   assign hi_bit = mem_data_in_b;
   assign w_hi = w_db;
   always_comb begin
      we_a = 1'b0;
      we_b = 1'b0;
      wd_a = w_da;
      wd_b = w_db;
      wa_b = w_addr_b;
      case (arr_sel_in)
         LBR_ARR_16X2: begin
            // [RULE_01] two independent memories
            we_a = wr_go && mem_a_en_in;
            we_b = wr_go && mem_b_en_in;
            if (dual_port_in) begin
               // [RULE_07] one memory mirrored in both tables
               // [RULE_20] write address from first generator inputs
               we_a = wr_go;
               we_b = wr_go;
               wd_b = w_da;
               wa_b = w_addr_a;
            end
         end
         LBR_ARR_16X1: begin
            // [RULE_02] only generator A is memory
            we_a = wr_go;
         end
         LBR_ARR_32X1: begin
            // [RULE_12] fifth address bit picks the table
            we_a = wr_go && !w_hi;
            we_b = wr_go && w_hi;
            wd_b = w_da;
         end
         LBR_ARR_LOGIC: begin
            we_a = 1'b0;
         end
         default: begin
            we_a = 1'b0;
         end
      endcase
   end

   // =====================================================
   // Lookup generators
   // =====================================================
   logic rd_a;
   logic rd_b;
   // [RULE_06] [RULE_10] shared port, four inputs address the cell
   lbr_cell #(.DEPTH(LBR_LUT_BITS)) u_lut_a (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(we_a),
      .wr_addr_in(w_addr_a),
      .wr_data_in(wd_a),
      .cfg_load_in(cfg_load_in),
      .cfg_table_in(cfg_lut_a_in),
      .rd_addr_in(addr_a),
      .rd_data_out(rd_a),
      .rd_addr2_unused_out()
   );
   // [RULE_08] second read port runs beside the write
   lbr_cell #(.DEPTH(LBR_LUT_BITS)) u_lut_b (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(we_b),
      .wr_addr_in(wa_b),
      .wr_data_in(wd_b),
      .cfg_load_in(cfg_load_in),
      .cfg_table_in(cfg_lut_b_in),
      .rd_addr_in(addr_b),
      .rd_data_out(rd_b),
      .rd_addr2_unused_out()
   );

   // =====================================================
   // Read path and third generator
   // =====================================================
   logic mem_a_val;
   logic third_val;
   // [RULE_09] read identical in all modes
   assign mem_a_val = (arr_sel_in == LBR_ARR_32X1) ? (hi_bit ? rd_b : rd_a) : rd_a;
   // [RULE_14] third generator of both outputs and second data input
   assign third_val = cfg_lut_third_in[{mem_data_in_b, rd_b, mem_a_val}];
   assign single_port_read_out = mem_a_val;

   // [RULE_13] comb outputs of the addressed cells, registered one system clock late
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         comb_a_out <= 1'b0;
         comb_b_out <= 1'b0;
      end else begin
         comb_a_out <= out_a_third_in ? third_val : mem_a_val;
         comb_b_out <= out_b_third_in ? third_val : rd_b;
      end
   end

   function automatic logic ff_pick(input logic [1:0] sel, input logic mem,
                                    input logic thr, input logic dat);
      case (sel)
         LBR_FF_SEL_MEM: ff_pick = mem;
         LBR_FF_SEL_THIRD: ff_pick = thr;
         LBR_FF_SEL_DATA: ff_pick = dat;
         default: ff_pick = mem;
      endcase
   endfunction : ff_pick

   // [RULE_14] block flip-flops on their own clock edge
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ff_a_out <= 1'b0;
         ff_b_out <= 1'b0;
      end else if (ff_edge) begin
         ff_a_out <= ff_pick(ff_a_sel_in, mem_a_val, third_val, mem_data_in_a);
         ff_b_out <= ff_pick(ff_b_sel_in, rd_b, third_val, mem_data_in_a);
      end
   end

   // =====================================================
   // Assertions
   // =====================================================
   sequence edge_wr_s;
      edge_mode_in && wr_edge && wr_enable;
   endsequence
   // [RULE_03] edge write pulse follows qualified edge
   edge_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_03]
      edge_wr_s |=> write_pulse_out || !edge_mode_in)
      else $error("edge write pulse missing");
   // [RULE_03] no pulse without edge
   no_stray_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_03]
      (edge_mode_in && $past(edge_mode_in) && !$past(wr_edge)) |-> !write_pulse_out)
      else $error("write pulse without edge");
   // [RULE_04] level strobe equals enable
   level_strobe_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_04]
      !edge_mode_in |-> (write_pulse_out == wr_enable))
      else $error("level strobe mismatch");
   // [RULE_15] latched enable on edge
   latch_we_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_15]
      wr_edge |=> lat_we_reg == $past(wr_enable))
      else $error("enable not latched");
   // [RULE_07] dual port writes both tables
   dual_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_07]
      (arr_sel_in == LBR_ARR_16X2 && dual_port_in) |-> (we_a == we_b))
      else $error("dual port write split");
   // [RULE_12] 32x1 writes one table only
   one_table_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_12]
      (arr_sel_in == LBR_ARR_32X1) |-> !(we_a && we_b))
      else $error("both tables written");
   // [RULE_02] logic mode never writes
   logic_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_02]
      (arr_sel_in == LBR_ARR_LOGIC) |-> !(we_a || we_b))
      else $error("logic table written");
   // [RULE_16] edges alternate with polarity
   // A polarity flip legally gives two edges in a row, so only a steady flag is held
   edge_alt_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_16]
      (wr_edge ##1 $stable(wclk_neg)) |-> !wr_edge)
      else $error("write edge repeats");
   // [RULE_16] flip-flops hold off edge
   ff_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_16]
      !ff_edge |=> ($stable(ff_a_out) && $stable(ff_b_out)))
      else $error("flip-flop moved off its edge");
   // Dual-port write strobe
   sequence dual_wr_s;
      arr_sel_in == LBR_ARR_16X2 && dual_port_in && wr_go;
   endsequence
   // [RULE_20] dual-port write address
   dual_addr_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_20]
      dual_wr_s |-> (wa_b == w_addr_a && wd_b == wd_a))
      else $error("dual port write address split");
   // [RULE_12] fifth bit steers write
   hi_steer_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_12]
      (arr_sel_in == LBR_ARR_32X1 && wr_go) |-> (we_b == w_hi && we_a == !w_hi))
      else $error("32x1 write steered wrong");
endmodule : lbr_block
`default_nettype wire

// ===== tb/lbr_fabric_model.sv
// Fabric-side user logic model that drives the block's memory pins
`timescale 1ns/1ns
`default_nettype none
module lbr_fabric_model (
   // Clock
   input wire logic clk_sys_in,
   // Requests from the bench
   input wire logic [3:0] req_addr_a_in,
   input wire logic [3:0] req_addr_b_in,
   input wire logic req_data_in,
   input wire logic req_third_in,
   input wire logic req_wr_in,
   // Fabric pins towards the block
   output logic [3:0] lut_a_inputs_out,
   output logic [3:0] lut_b_inputs_out,
   output logic direct_input_pin_out,
   output logic third_lut_input_pin_out,
   output logic set_reset_pin_out
);
   // ==========================================
   // Pin launch
   // ==========================================
   // clock never stopped
   // Launch on the falling edge so pins are settled well before sampling
   always_ff @(negedge clk_sys_in) begin
      lut_a_inputs_out <= req_addr_a_in;
      lut_b_inputs_out <= req_addr_b_in;
      direct_input_pin_out <= req_data_in;
      third_lut_input_pin_out <= req_third_in;
   end
   // enable active high
   // Enable is never inverted here; the block cannot invert it either
   always_ff @(negedge clk_sys_in) begin
      set_reset_pin_out <= req_wr_in;
   end
endmodule : lbr_fabric_model
`default_nettype wire

// ===== tb/lbr_block_tb.sv
// Self-checking testbench for the logic block distributed RAM
`timescale 1ns/1ns
`default_nettype none
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin bad_count++; \
   $display("CHECK FAILED at %0t: output mismatch", $time); end end
module lbr_block_tb;
   import lbr_pkg::*;
   // ==========================================
   // Signals
   // ==========================================
   logic clk_sys_in, rst_n_in;
   lbr_arr_t arr_sel;
   logic mem_a_en, mem_b_en, dual_port, edge_mode, wclk_falling, ff_falling, cfg_load;
   logic [15:0] cfg_lut_a, cfg_lut_b;
   logic [7:0] cfg_lut_third;
   logic [1:0] ff_a_sel, ff_b_sel;
   logic out_a_third, out_b_third;
   logic [3:0] req_a, req_b, lut_a, lut_b;
   logic req_data, req_third, req_wr, pin_data, pin_third, pin_we;
   logic comb_a_out, comb_b_out, ff_a_out, ff_b_out, single_port_read_out, write_pulse_out;
   int bad_count, total_checks;
   // ==========================================
   // Instances
   // ==========================================
   lbr_fabric_model i_lbr_fabric_model (.clk_sys_in(clk_sys_in), .req_addr_a_in(req_a),
      .req_addr_b_in(req_b), .req_data_in(req_data), .req_third_in(req_third),
      .req_wr_in(req_wr), .lut_a_inputs_out(lut_a), .lut_b_inputs_out(lut_b),
      .direct_input_pin_out(pin_data), .third_lut_input_pin_out(pin_third),
      .set_reset_pin_out(pin_we));
   lbr_block i_lbr_block (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .arr_sel_in(arr_sel),
      .mem_a_en_in(mem_a_en), .mem_b_en_in(mem_b_en), .dual_port_in(dual_port),
      .edge_mode_in(edge_mode), .wclk_falling_in(wclk_falling), .ff_falling_in(ff_falling),
      .cfg_load_in(cfg_load), .cfg_lut_a_in(cfg_lut_a), .cfg_lut_b_in(cfg_lut_b),
      .cfg_lut_third_in(cfg_lut_third), .ff_a_sel_in(ff_a_sel), .ff_b_sel_in(ff_b_sel),
      .out_a_third_in(out_a_third), .out_b_third_in(out_b_third), .lut_a_inputs_in(lut_a),
      .lut_b_inputs_in(lut_b), .direct_input_pin_in(pin_data),
      .third_lut_input_pin_in(pin_third), .set_reset_pin_in(pin_we), .comb_a_out(comb_a_out),
      .comb_b_out(comb_b_out), .ff_a_out(ff_a_out), .ff_b_out(ff_b_out),
      .single_port_read_out(single_port_read_out), .write_pulse_out(write_pulse_out));
   // ==========================================
   // Clock and tasks
   // ==========================================
   // Free-running system clock, 10 ns period
   always #5 clk_sys_in = ~clk_sys_in;
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask : tick
   // Write: hold request until the strobe shows, bounded wait
   task automatic wr(input logic [3:0] a, input logic [3:0] b, input logic d, input logic th,
                     input logic we, input logic exp);
      logic seen;
      seen = 1'b0;
      // Non-blocking so the model's falling-edge launch always sees the old request
      req_a <= a;
      req_b <= b;
      req_data <= d;
      req_third <= th;
      req_wr <= we;
      for (int n = 0; n < 16 && !seen; n++) begin
         tick(1);
         if (write_pulse_out === 1'b1) seen = 1'b1;
      end
      `CHK(seen, exp)
      // Edge mode pulse lasts one cycle only
      if (seen && edge_mode) begin
         tick(1);
         `CHK(write_pulse_out, 1'b0)
      end
      req_wr <= 1'b0;
      tick(6);
   endtask : wr
   // Read: pins pass two sync flops, so allow them to settle
   task automatic rd(input logic [3:0] a, input logic [3:0] b, input logic th,
                     input logic exp);
      req_a <= a;
      req_b <= b;
      req_third <= th;
      tick(6);
      `CHK(single_port_read_out, exp)
   endtask : rd
   task automatic stop_test;
      if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // ==========================================
   // Tests
   // ==========================================
   // Watchdog well beyond the expected run length
   initial begin
      #300000;
      bad_count++;
      stop_test();
   end
   initial begin
      clk_sys_in = 1'b0; rst_n_in = 1'b0; arr_sel = LBR_ARR_16X2; mem_a_en = 1'b1;
      mem_b_en = 1'b1; dual_port = 1'b0; edge_mode = 1'b1; wclk_falling = 1'b0;
      ff_falling = 1'b0; cfg_load = 1'b0; cfg_lut_a = 16'h0000; cfg_lut_b = 16'h0000;
      cfg_lut_third = 8'h00; ff_a_sel = LBR_FF_SEL_MEM; ff_b_sel = LBR_FF_SEL_MEM;
      out_a_third = 1'b0; out_b_third = 1'b0; req_a = 4'h0; req_b = 4'h0;
      req_data = 1'b0; req_third = 1'b0; req_wr = 1'b0; bad_count = 0; total_checks = 0;
      tick(5);
      rst_n_in = 1'b1;
      tick(1);
      `CHK(write_pulse_out, 1'b0)
      `CHK(single_port_read_out, 1'b0)
      // Edge-triggered 16x2: both tables written on one strobe
      wr(4'h5, 4'h5, 1'b1, 1'b1, 1'b1, 1'b1);
      rd(4'h5, 4'h5, 1'b0, 1'b1);
      `CHK(comb_b_out, 1'b1)
      rd(4'h4, 4'h4, 1'b0, 1'b0);
      `CHK(comb_b_out, 1'b0)
      // Enable low on the edge: nothing is written
      wr(4'h5, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0);
      rd(4'h5, 4'h5, 1'b0, 1'b1);
      // Falling write edge, both generators follow it
      wclk_falling = 1'b1;
      wr(4'h6, 4'h6, 1'b1, 1'b0, 1'b1, 1'b1);
      rd(4'h6, 4'h6, 1'b0, 1'b1);
      `CHK(comb_b_out, 1'b0)
      // Level-sensitive: strobe follows enable for both tables
      wclk_falling = 1'b0;
      edge_mode = 1'b0;
      wr(4'h7, 4'h7, 1'b1, 1'b1, 1'b1, 1'b1);
      `CHK(write_pulse_out, 1'b0)
      rd(4'h7, 4'h7, 1'b0, 1'b1);
      `CHK(comb_b_out, 1'b1)
      // 32x1: third pin becomes address bit four
      edge_mode = 1'b1;
      arr_sel = LBR_ARR_32X1;
      wr(4'h9, 4'h9, 1'b1, 1'b1, 1'b1, 1'b1);
      rd(4'h9, 4'h9, 1'b1, 1'b1);
      rd(4'h9, 4'h9, 1'b0, 1'b0);
      // Dual-port: write via first inputs, second port reads independently
      arr_sel = LBR_ARR_16X2;
      dual_port = 1'b1;
      wr(4'h3, 4'hC, 1'b1, 1'b0, 1'b1, 1'b1);
      rd(4'hC, 4'h3, 1'b0, 1'b0);
      `CHK(comb_b_out, 1'b1)
      dual_port = 1'b0;
      // Flip-flops take the first data input and the third generator
      // Third index is {second data, table B, table A}: 2 gives 1, 6 gives 0
      ff_falling = 1'b1;
      ff_a_sel = LBR_FF_SEL_DATA;
      ff_b_sel = LBR_FF_SEL_THIRD;
      out_b_third = 1'b1;
      cfg_lut_third = 8'h04;
      req_data <= 1'b1;
      tick(6);
      `CHK(ff_a_out, 1'b1)
      `CHK(ff_b_out, 1'b1)
      `CHK(comb_b_out, 1'b1)
      req_data <= 1'b0;
      req_third <= 1'b1;
      tick(6);
      `CHK(ff_a_out, 1'b0)
      `CHK(ff_b_out, 1'b0)
      `CHK(comb_b_out, 1'b0)
      // Logic arrangement: four-input AND, writes refused
      arr_sel = LBR_ARR_LOGIC;
      cfg_lut_a = 16'h8000;
      cfg_load = 1'b1;
      tick(1);
      cfg_load = 1'b0;
      rd(4'hF, 4'h0, 1'b0, 1'b1);
      `CHK(comb_a_out, 1'b1)
      rd(4'hE, 4'h0, 1'b0, 1'b0);
      // The strobe still shows, but no table may take the bit
      wr(4'h2, 4'h2, 1'b1, 1'b1, 1'b1, 1'b1);
      rd(4'h2, 4'h2, 1'b0, 1'b0);
      stop_test();
   end
endmodule : lbr_block_tb
`default_nettype wire
